/* hw/gsel_pkg.sv */
// Purpose: Shared constants and types for the parameter group selector
// Assumes: 32-bit APB, word-aligned registers
// Notes:   Group numbers are 1..8 on the bus, 0..7 inside the logic
package gsel_pkg;

  // Group count and widths
  localparam int unsigned GROUP_COUNT = 8;
  localparam int unsigned GROUP_W     = 4;
  localparam int unsigned SYNC_W      = 13;

  // Register byte offsets
  localparam logic [7:0] USED_OFF   = 8'h00;
  localparam logic [7:0] FORCE_OFF  = 8'h04;
  localparam logic [7:0] REMOTE_OFF = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0c;
  localparam logic [7:0] EVENT_OFF  = 8'h10;

  // Field positions
  localparam int unsigned FORCE_EN_BIT   = 0;
  localparam int unsigned FORCE_GRP_LSB  = 4;
  localparam int unsigned STAT_ACT_LSB   = 0;
  localparam int unsigned STAT_REQ_LSB   = 8;
  localparam int unsigned STAT_MASK_LSB  = 16;
  localparam int unsigned STAT_FORCE_BIT = 24;

  // Reset values
  localparam logic [GROUP_W-1:0] USED_RESET   = 4'h1;
  localparam logic [GROUP_W-1:0] SELECT_NONE  = 4'h0;
  localparam logic [2:0]         ACTIVE_RESET = 3'h0;

  // Event flags, also the event register layout
  typedef struct packed {
    logic force_mode;
    logic fail_force;
    logic fail_prio;
    logic fail_not_cfg;
  } gsel_evt_type;

  localparam gsel_evt_type EVT_RESET = '{default: 1'b0};

endpackage

/* hw/gsel_sync.sv */
// Purpose: Two-flop synchroniser with rising edge detect
// Assumes: Inputs are asynchronous to pclk
// Notes:   Edge is taken from the second and third stages only
`timescale 1ns/1ps
module gsel_sync #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Asynchronous inputs
  input  wire logic [W-1:0] async_in,
  // Synchronised level and edge
  output logic      [W-1:0] level_q,
  output logic      [W-1:0] rise_q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q  <= '0;
      level_q <= '0;
      prev_q  <= '0;
    end else begin
      meta_q  <= async_in;
      level_q <= meta_q;
      prev_q  <= level_q;
    end
  end

  // Rise pulse, one cycle wide
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_q <= '0;
    end else begin
      rise_q <= level_q & ~prev_q;
    end
  end

endmodule

/* hw/gsel_top.sv */
// Purpose: Priority selector of the active parameter group, APB slave
// Assumes: Activation inputs and panel pins are asynchronous, one clock
// Notes:   Zero-wait APB, answer in the first access cycle
`timescale 1ns/1ps

module gsel_top
  import gsel_pkg::*;
(
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Group activation pins
  input  wire logic [GROUP_COUNT-1:0] group_req_in,
  // Operator panel force pins
  input  wire logic                   panel_force_strobe,
  input  wire logic [GROUP_W-1:0]     panel_force_group,
  // Active group
  output logic [GROUP_W-1:0]          active_group,
  output logic [GROUP_COUNT-1:0]      active_onehot,
  output logic [GROUP_COUNT-1:0]      defaults_load,
  // Events
  output gsel_evt_type                evt_on,
  output gsel_evt_type                evt_off
);

  // Highest priority set bit
  function automatic logic [2:0] first_one(input logic [GROUP_COUNT-1:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = GROUP_COUNT - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  logic [GROUP_W-1:0]     used_q;
  logic                   force_en_q;
  logic [GROUP_W-1:0]     force_sel_q;
  logic [GROUP_W-1:0]     remote_sel_q;
  logic [2:0]             active_q;
  logic                   release_q;
  gsel_evt_type           flags_q;
  gsel_evt_type           flags_d;
  logic [SYNC_W-1:0]      sync_lvl;
  logic [SYNC_W-1:0]      sync_rise;
  logic [GROUP_COUNT-1:0] mask;
  logic [GROUP_COUNT-1:0] blocked;
  logic [GROUP_COUNT-1:0] lvl_en;
  logic [GROUP_COUNT-1:0] rise_ok;
  logic [GROUP_COUNT-1:0] rise_blk;
  logic [GROUP_COUNT-1:0] rise_bad;
  logic [31:0]            rdata_d;
  logic                   rd_hit;
  logic                   wr_en;
  logic                   wr_used;
  logic                   wr_force;
  logic                   wr_remote;
  logic [GROUP_W-1:0]     used_new;
  logic [GROUP_W-1:0]     force_grp;
  logic [GROUP_W-1:0]     remote_grp;
  logic                   force_req;
  logic [GROUP_W-1:0]     force_tgt;
  logic                   force_ok;
  logic                   force_nc;
  logic                   force_rej;
  logic                   remote_ok;
  logic                   remote_nc;
  logic                   remote_blk;
  logic                   auto_fire;
  logic                   shrink;

  // Pin synchronisers
  gsel_sync #(
    .W (SYNC_W)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({panel_force_strobe, panel_force_group, group_req_in}),
    .level_q  (sync_lvl),
    .rise_q   (sync_rise)
  );

  // APB decode
  assign wr_en     = psel & penable & pwrite & pready;
  assign wr_used   = wr_en & (paddr == USED_OFF);
  assign wr_force  = wr_en & (paddr == FORCE_OFF);
  assign wr_remote = wr_en & (paddr == REMOTE_OFF);
  assign used_new  = pwdata[GROUP_W-1:0];
  assign force_grp = pwdata[FORCE_GRP_LSB +: GROUP_W];
  assign remote_grp = pwdata[GROUP_W-1:0];

  generate
    for (genvar g = 0; g < GROUP_COUNT; g++) begin : g_grp
      assign mask[g]   = (4'(g) < used_q);
      assign lvl_en[g] = sync_lvl[g] & mask[g];
      if (g == 0) begin : g_top
        assign blocked[g] = 1'b0;
      end else begin : g_low
        assign blocked[g] = |lvl_en[g-1:0];
      end
    end
  endgenerate

  // Only a rise is a request, except held levels on force release; held levels join the priority pick
  assign rise_ok  = sync_rise[GROUP_COUNT-1:0] & mask & ~blocked;
  assign rise_blk = sync_rise[GROUP_COUNT-1:0] & mask & blocked;
  assign rise_bad = sync_rise[GROUP_COUNT-1:0] & ~mask;
  assign auto_fire = ~force_en_q & (|rise_ok);
  assign shrink    = wr_used & (used_new >= 4'h1) & (used_new <= 4'h8)
                     & ({1'b0, active_q} >= used_new);

  // Forced select acts as one pulse
  always_comb begin
    force_req = 1'b0;
    force_tgt = SELECT_NONE;
    if (wr_force && force_grp != SELECT_NONE) begin
      force_req = 1'b1;
      force_tgt = force_grp;
    end else if (sync_rise[SYNC_W-1] && sync_lvl[SYNC_W-2 -: GROUP_W] != SELECT_NONE) begin
      force_req = 1'b1;
      force_tgt = sync_lvl[SYNC_W-2 -: GROUP_W];
    end
  end

  // Needs force mode and enabled target
  assign force_ok  = force_req & force_en_q & (force_tgt <= used_q) & (force_tgt <= 4'h8);
  assign force_nc  = force_req & force_en_q & ~force_ok;
  assign force_rej = force_req & ~force_en_q;

  assign remote_nc  = wr_remote & ~force_en_q & (remote_grp != SELECT_NONE)
                      & ((remote_grp > used_q) | (remote_grp > 4'h8));
  assign remote_blk = wr_remote & ~force_en_q & (remote_grp != SELECT_NONE) & ~remote_nc
                      & blocked[3'(remote_grp - 4'h1)];
  assign remote_ok  = wr_remote & ~force_en_q & (remote_grp != SELECT_NONE)
                      & ~remote_nc & ~remote_blk;

  // Configuration registers
  // Reset to one group
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      used_q       <= USED_RESET;
      force_en_q   <= 1'b0;
      force_sel_q  <= SELECT_NONE;
      remote_sel_q <= SELECT_NONE;
      release_q    <= 1'b0;
    end else begin
      if (wr_used && used_new >= 4'h1 && used_new <= 4'h8) begin
        used_q <= used_new;
      end
      if (wr_force) begin
        force_en_q  <= pwdata[FORCE_EN_BIT];
        force_sel_q <= force_grp;
      end
      if (wr_remote) begin
        remote_sel_q <= remote_grp;
      end
      release_q <= wr_force & force_en_q & ~pwdata[FORCE_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      defaults_load <= '0;
    end else begin
      for (int i = 0; i < GROUP_COUNT; i++) begin
        defaults_load[i] <= wr_used && used_new <= 4'h8 && 4'(i) < used_new && !mask[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_q <= ACTIVE_RESET;
    end else if (shrink) begin
      active_q <= ACTIVE_RESET;
    end else if (force_ok) begin
      active_q <= 3'(force_tgt - 4'h1);
    end else if (release_q && |lvl_en) begin
      active_q <= first_one(lvl_en);
    end else if (remote_ok) begin
      active_q <= 3'(remote_grp - 4'h1);
    end else if (auto_fire) begin
      active_q <= first_one(lvl_en | rise_ok);
    end
  end

  always_comb begin
    flags_d = flags_q;
    flags_d.force_mode = force_en_q;
    if (force_ok || remote_ok || auto_fire) begin
      flags_d.fail_not_cfg = 1'b0;
      flags_d.fail_prio    = 1'b0;
      flags_d.fail_force   = 1'b0;
    end
    if ((!force_en_q && |rise_bad) || force_nc || remote_nc) begin
      flags_d.fail_not_cfg = 1'b1;
    end
    if ((!force_en_q && |rise_blk) || remote_blk) begin
      flags_d.fail_prio = 1'b1;
    end
    if (force_rej) begin
      flags_d.fail_force = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= EVT_RESET;
      evt_on  <= EVT_RESET;
      evt_off <= EVT_RESET;
    end else begin
      flags_q <= flags_d;
      evt_on  <= flags_d & ~flags_q;
      evt_off <= ~flags_d & flags_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_group  <= 4'h1;
      active_onehot <= 8'h01;
    end else begin
      active_group  <= {1'b0, active_q} + 4'h1;
      active_onehot <= 8'h01 << active_q;
    end
  end

  // APB read mux
  always_comb begin
    rdata_d = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (paddr)
      USED_OFF: begin
        rdata_d[GROUP_W-1:0] = used_q;
      end
      FORCE_OFF: begin
        rdata_d[FORCE_EN_BIT] = force_en_q;
        rdata_d[FORCE_GRP_LSB +: GROUP_W] = force_sel_q;
      end
      REMOTE_OFF: begin
        rdata_d[GROUP_W-1:0] = remote_sel_q;
      end
      STATUS_OFF: begin
        rdata_d[STAT_ACT_LSB +: GROUP_W] = {1'b0, active_q} + 4'h1;
        rdata_d[STAT_REQ_LSB +: GROUP_COUNT] = sync_lvl[GROUP_COUNT-1:0];
        rdata_d[STAT_MASK_LSB +: GROUP_COUNT] = mask;
        rdata_d[STAT_FORCE_BIT] = force_en_q;
      end
      EVENT_OFF: begin
        rdata_d[3:0] = flags_q;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // APB answer, one access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      prdata  <= (psel & ~penable & ~pwrite) ? rdata_d : 32'h0000_0000;
      pslverr <= psel & ~penable & ~rd_hit;
    end
  end

  // Checks
  one_active_a: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot(active_onehot))
    else $error("active group not one-hot");

  reset_group_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> active_group == 4'h1)
    else $error("active group not one after reset");

  force_apply_a: assert property (@(posedge pclk) disable iff (!presetn)
    force_ok |=> ##1 active_group == $past(force_tgt, 2))
    else $error("forced group not applied");

  force_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    force_en_q && !force_ok && !shrink |=> active_q == $past(active_q))
    else $error("group changed while forcing");

  force_refuse_a: assert property (@(posedge pclk) disable iff (!presetn)
    force_req && !force_en_q |=> flags_q.fail_force && active_q == $past(active_q))
    else $error("forced change taken with force mode off");

  level_prio_a: assert property (@(posedge pclk) disable iff (!presetn)
    auto_fire && !shrink && !force_ok && !release_q && !remote_ok
      |=> active_q == first_one($past(lvl_en | rise_ok)))
    else $error("priority winner wrong");

  remote_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    remote_blk |=> flags_q.fail_prio && (evt_on.fail_prio || $past(flags_q.fail_prio)))
    else $error("blocked remote request not flagged");

  release_take_a: assert property (@(posedge pclk) disable iff (!presetn)
    release_q && |lvl_en && !shrink && !force_ok |=> active_q == first_one($past(lvl_en)))
    else $error("levels did not retake on release");

  pulse_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !auto_fire && !force_ok && !remote_ok && !release_q && !shrink
      |=> active_q == $past(active_q))
    else $error("active group moved without request");

endmodule

/* verification/gsel_far_side.sv */
// Purpose: Far side model: activation pins and operator panel
// Assumes: Driven only through its tasks, one request at a time
// Notes:   A released panel group line shows the inverse of its last value
`timescale 1ns/1ps
module gsel_far_side
  import gsel_pkg::*;
(
  // Clock
  input  wire logic                   pclk,
  // Pins toward the selector
  output logic      [GROUP_COUNT-1:0] group_req_in,
  output logic                        panel_force_strobe,
  output logic      [GROUP_W-1:0]     panel_force_group
);
  initial begin
    group_req_in       = '0;
    panel_force_strobe = 1'b0;
    panel_force_group  = 4'hf;
  end
  task automatic pulse(input int g);
    @(posedge pclk);
    group_req_in[g-1] <= 1'b1;
    repeat (2) @(posedge pclk);
    group_req_in[g-1] <= 1'b0;
  endtask
  task automatic level(input int g, input logic on);
    @(posedge pclk);
    group_req_in[g-1] <= on;
  endtask
  // panel request, group held around strobe
  task automatic panel(input logic [GROUP_W-1:0] g);
    @(posedge pclk);
    panel_force_group <= g;
    repeat (3) @(posedge pclk);
    panel_force_strobe <= 1'b1;
    repeat (4) @(posedge pclk);
    panel_force_strobe <= 1'b0;
    repeat (4) @(posedge pclk);
    panel_force_group <= ~g;
  endtask
endmodule

/* verification/gsel_top_test.sv */
// Purpose: Self-checking bench of the group selector
// Assumes: Zero-wait APB slave, far side model on the pins
// Notes:   Random remote requests from an LFSR seeded at 7dab
`timescale 1ns/1ps
module gsel_top_test
  import gsel_pkg::*;
;
  logic                   pclk;
  logic                   presetn;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [7:0]             paddr;
  logic [31:0]            pwdata;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic [GROUP_COUNT-1:0] group_req_in;
  logic                   panel_force_strobe;
  logic [GROUP_W-1:0]     panel_force_group;
  logic [GROUP_W-1:0]     active_group;
  logic [GROUP_COUNT-1:0] active_onehot;
  logic [GROUP_COUNT-1:0] defaults_load;
  gsel_evt_type           evt_on;
  gsel_evt_type           evt_off;
  logic [GROUP_COUNT-1:0] dl_seen;
  logic [3:0]             on_seen;
  logic [3:0]             off_seen;
  logic [31:0]            lfsr;
  logic [31:0]            rd;
  logic                   err;
  int                     err_total;
  int                     n_tests;
  int                     cyc;

  gsel_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .group_req_in(group_req_in), .panel_force_strobe(panel_force_strobe),
    .panel_force_group(panel_force_group), .active_group(active_group),
    .active_onehot(active_onehot), .defaults_load(defaults_load), .evt_on(evt_on),
    .evt_off(evt_off));

  gsel_far_side far (.pclk(pclk), .group_req_in(group_req_in),
    .panel_force_strobe(panel_force_strobe), .panel_force_group(panel_force_group));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Collects every defaults pulse
  initial dl_seen = '0;
  always @(posedge pclk) dl_seen <= dl_seen | defaults_load;

  // Collects every event pulse
  initial on_seen = '0;
  initial off_seen = '0;
  always @(posedge pclk) on_seen <= on_seen | evt_on;
  always @(posedge pclk) off_seen <= off_seen | evt_off;

  initial cyc = 0;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] force_word(input int g, input logic en);
    return (32'(g) << FORCE_GRP_LSB) | 32'(en);
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_act(input int g);
    int n;
    n = 0;
    while (active_group !== 4'(g) && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk("active_group", 32'(g), 32'(active_group));
    chk("active_onehot", 32'(1) << (g - 1), 32'(active_onehot));
  endtask

  task automatic stays(input int g);
    repeat (12) @(posedge pclk);
    chk("held group", 32'(g), 32'(active_group));
  endtask

  task automatic flag(input string what, input int b);
    apb(1'b0, EVENT_OFF, 32'h0);
    chk(what, 32'h1, 32'(rd[b]));
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    presetn   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    err_total = 0;
    n_tests   = 0;
    lfsr      = 32'h7dab;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    wait_act(1);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk("status", 32'h0001_0001, rd);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped err", 32'h1, 32'(err));
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, USED_OFF, 32'h9);
    apb(1'b0, USED_OFF, 32'h0);
    chk("used", 32'h1, 32'(rd[3:0]));
    done("reset");
    apb(1'b1, USED_OFF, 32'h4);
    repeat (3) @(posedge pclk);
    chk("defaults", 32'h0e, 32'(dl_seen));
    apb(1'b1, USED_OFF, 32'h8);
    repeat (3) @(posedge pclk);
    chk("defaults", 32'hfe, 32'(dl_seen));
    apb(1'b0, STATUS_OFF, 32'h0);
    chk("mask", 32'hff, 32'(rd[23:16]));
    done("used");
    for (int g = 1; g <= 8; g++) begin
      apb(1'b1, REMOTE_OFF, 32'(g));
      wait_act(g);
    end
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      apb(1'b1, REMOTE_OFF, 32'(lfsr[2:0]) + 32'h1);
      wait_act(int'(lfsr[2:0]) + 1);
    end
    done("remote");
    far.pulse(3);
    wait_act(3);
    stays(3);
    far.pulse(7);
    wait_act(7);
    far.level(5, 1'b1);
    far.level(2, 1'b1);
    wait_act(2);
    apb(1'b1, REMOTE_OFF, 32'h4);
    stays(2);
    flag("fail_prio", 1);
    far.pulse(6);
    stays(2);
    far.level(2, 1'b0);
    far.level(5, 1'b0);
    done("pins");
    apb(1'b1, FORCE_OFF, force_word(6, 1'b0));
    stays(2);
    flag("fail_force", 2);
    apb(1'b1, FORCE_OFF, force_word(0, 1'b1));
    flag("force_mode", 3);
    apb(1'b1, FORCE_OFF, force_word(3, 1'b1));
    wait_act(3);
    apb(1'b1, USED_OFF, 32'h4);
    apb(1'b1, FORCE_OFF, force_word(7, 1'b1));
    stays(3);
    flag("fail_not_cfg", 0);
    far.panel(4'h2);
    wait_act(2);
    far.pulse(4);
    stays(2);
    apb(1'b1, FORCE_OFF, force_word(0, 1'b0));
    stays(2);
    apb(1'b1, FORCE_OFF, force_word(0, 1'b1));
    apb(1'b1, FORCE_OFF, force_word(4, 1'b1));
    wait_act(4);
    far.level(3, 1'b1);
    stays(4);
    apb(1'b1, FORCE_OFF, force_word(0, 1'b0));
    wait_act(3);
    far.level(3, 1'b0);
    chk("evt_on seen", 32'hf, 32'(on_seen));
    chk("evt_off seen", 32'hf, 32'(off_seen));
    done("force");
    report_and_stop();
  end
endmodule
